//--- core/dcr_top.v
// debug comparator a/c registers and trace read-out, apb slave
// assumes apb master on pclk; core bus and reset request on pclk
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "dcr_defines.vh"

module dcr_top #(
  parameter FIFO_AW = 3
) (
  // apb
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // core bus
  input  wire        core_valid,
  input  wire        core_read,
  input  wire        core_paged,
  input  wire [2:0]  core_page,
  input  wire [16:0] core_addr,
  // neighbouring compare registers
  input  wire [15:0] cmp_a_value,
  input  wire [7:0]  cmp_c_high,
  // system reset request
  input  wire        core_reset_req,
  // match results
  output wire        match_a,
  output wire        match_c
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [7:0]  comparator_c_low_byte;
  reg         direction_qualifier_enable;
  reg         direction_match_value;
  reg         paged_access_qualifier;
  reg         cax_bit16;
  reg         debug_module_enable;
  reg         trigger_at_begin;
  reg         event_only;

  wire [5:0]  idx;
  wire        aligned;
  wire        acc;
  wire        wr_done;
  wire        preserve;
  wire        clear_all;
  wire [16:0] match_addr_a;
  wire [16:0] match_addr_c;
  wire [16:0] trace_word;
  wire        trace_valid;
  wire        fifo_ready;
  wire        pop;
  reg  [7:0]  next_rbyte;
  reg         next_err;
  reg  [7:0]  next_ccl;
  reg         next_rwen;
  reg         next_rwval;
  reg         next_paged_access_qualifier;
  reg         next_b16;
  reg         next_en;
  reg         next_begin;
  reg         next_evonly;

  assign idx     = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign acc     = psel && penable && !pready;
  assign wr_done = psel && penable && pready && pwrite && !pslverr;

  // end-trace reset keeps contents
  assign preserve  = debug_module_enable && !trigger_at_begin;
  assign clear_all = core_reset_req && !preserve;

  // ----------------------------------------
  // trace word fields at the read point
  // ----------------------------------------
  wire        trace_info;
  wire [7:0]  trace_hi;
  wire [7:0]  trace_lo;
  wire        trace_b16;

  // event-only words carry nothing above the low byte
  assign trace_info = trace_valid && !event_only;
  assign trace_hi   = trace_word[15:8];
  assign trace_lo   = trace_word[7:0];
  assign trace_b16  = trace_word[16];

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function mapped;
    input [5:0] i;
    begin
      mapped = (i == `DCR_IDX_CCL) || (i == `DCR_IDX_FH) ||
               (i == `DCR_IDX_FL) || (i == `DCR_IDX_CAX) ||
               (i == `DCR_IDX_CTRL) || (i == `DCR_IDX_FX);
    end
  endfunction

  always @* begin
    next_rbyte = `DCR_RST_BYTE;
    next_err   = !aligned || !mapped(idx);
    case (idx)
      `DCR_IDX_CCL: begin
        next_rbyte = comparator_c_low_byte;
      end
      `DCR_IDX_FH: begin
        if (trace_info) begin
          next_rbyte = trace_hi;
        end
      end
      `DCR_IDX_FL: begin
        if (trace_valid) begin
          next_rbyte = trace_lo;
        end
      end
      `DCR_IDX_CAX: begin
        // bits 4..1 stay zero
        next_rbyte[`DCR_CAX_RWEN]   = direction_qualifier_enable;
        next_rbyte[`DCR_CAX_RWVAL]  = direction_match_value;
        next_rbyte[`DCR_CAX_PAGED_ACCESS_QUALIFIER] = paged_access_qualifier;
        next_rbyte[`DCR_CAX_B16]    = cax_bit16;
      end
      `DCR_IDX_CTRL: begin
        next_rbyte[`DCR_CTRL_EN]     = debug_module_enable;
        next_rbyte[`DCR_CTRL_BEGIN]  = trigger_at_begin;
        next_rbyte[`DCR_CTRL_EVONLY] = event_only;
      end
      `DCR_IDX_FX: begin
        if (trace_info) begin
          next_rbyte[`DCR_FX_B16] = trace_b16;
        end
      end
      default: begin
        next_rbyte = `DCR_RST_BYTE;
      end
    endcase
  end

  // ----------------------------------------
  // apb answer, one wait state
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= `DCR_RST_BIT;
      pslverr <= `DCR_RST_BIT;
    end else begin
      pready  <= acc;
      pslverr <= acc && next_err;
    end
  end

  // read data holds until the next read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `DCR_ZERO_WORD;
    end else if (acc && !pwrite) begin
      prdata <= {24'h000000, next_rbyte};
    end
  end

  // low byte read pops at the sampling of read data
  assign pop = acc && !pwrite && aligned && (idx == `DCR_IDX_FL);

  // ----------------------------------------
  // write strobes
  // ----------------------------------------
  // a write lands only at the completing edge of its access
  function wr_sel;
    input [5:0] i;
    input [5:0] target;
    input       strobe;
    begin
      wr_sel = strobe && (i == target);
    end
  endfunction

  // ----------------------------------------
  // compare settings
  // ----------------------------------------
  // a write in a core reset cycle is dropped
  always @* begin
    next_ccl    = comparator_c_low_byte;
    next_rwen   = direction_qualifier_enable;
    next_rwval  = direction_match_value;
    next_paged_access_qualifier = paged_access_qualifier;
    next_b16    = cax_bit16;
    if (clear_all) begin
      next_ccl    = `DCR_RST_BYTE;
      next_rwen   = `DCR_RST_BIT;
      next_rwval  = `DCR_RST_BIT;
      next_paged_access_qualifier = `DCR_RST_BIT;
      next_b16    = `DCR_RST_BIT;
    end else if (!core_reset_req) begin
      if (wr_sel(idx, `DCR_IDX_CCL, wr_done)) begin
        next_ccl = pwdata[7:0];
      end
      if (wr_sel(idx, `DCR_IDX_CAX, wr_done)) begin
        next_rwen   = pwdata[`DCR_CAX_RWEN];
        next_rwval  = pwdata[`DCR_CAX_RWVAL];
        next_paged_access_qualifier = pwdata[`DCR_CAX_PAGED_ACCESS_QUALIFIER];
        next_b16    = pwdata[`DCR_CAX_B16];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comparator_c_low_byte      <= `DCR_RST_BYTE;
      direction_qualifier_enable <= `DCR_RST_BIT;
      direction_match_value      <= `DCR_RST_BIT;
      paged_access_qualifier     <= `DCR_RST_BIT;
      cax_bit16                  <= `DCR_RST_BIT;
    end else begin
      comparator_c_low_byte      <= next_ccl;
      direction_qualifier_enable <= next_rwen;
      direction_match_value      <= next_rwval;
      paged_access_qualifier     <= next_paged_access_qualifier;
      cax_bit16                  <= next_b16;
    end
  end

  // ----------------------------------------
  // trace control
  // ----------------------------------------
  always @* begin
    next_en     = debug_module_enable;
    next_begin  = trigger_at_begin;
    next_evonly = event_only;
    if (clear_all) begin
      next_en     = `DCR_RST_BIT;
      next_begin  = `DCR_RST_BIT;
      next_evonly = `DCR_RST_BIT;
    end else if (!core_reset_req) begin
      if (wr_sel(idx, `DCR_IDX_CTRL, wr_done)) begin
        next_en     = pwdata[`DCR_CTRL_EN];
        next_begin  = pwdata[`DCR_CTRL_BEGIN];
        next_evonly = pwdata[`DCR_CTRL_EVONLY];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_module_enable <= `DCR_RST_BIT;
      trigger_at_begin    <= `DCR_RST_BIT;
      event_only          <= `DCR_RST_BIT;
    end else begin
      debug_module_enable <= next_en;
      trigger_at_begin    <= next_begin;
      event_only          <= next_evonly;
    end
  end

  // ----------------------------------------
  // comparators
  // ----------------------------------------
  dcr_cmp u_cmp_a (
    .pclk                       (pclk),
    .presetn                    (presetn),
    .core_valid                 (core_valid),
    .core_read                  (core_read),
    .core_paged                 (core_paged),
    .core_page                  (core_page),
    .core_addr                  (core_addr),
    .cmp_value                  ({cax_bit16, cmp_a_value}),
    .direction_qualifier_enable (direction_qualifier_enable),
    .direction_match_value      (direction_match_value),
    .paged_access_qualifier     (paged_access_qualifier),
    .match                      (match_a),
    .match_addr                 (match_addr_a)
  );

  dcr_cmp u_cmp_c (
    .pclk                       (pclk),
    .presetn                    (presetn),
    .core_valid                 (core_valid),
    .core_read                  (core_read),
    .core_paged                 (core_paged),
    .core_page                  (core_page),
    .core_addr                  (core_addr),
    .cmp_value                  ({1'b0, cmp_c_high, comparator_c_low_byte}),
    .direction_qualifier_enable (1'b0),
    .direction_match_value      (1'b0),
    .paged_access_qualifier     (1'b0),
    .match                      (match_c),
    .match_addr                 (match_addr_c)
  );

  // ----------------------------------------
  // trace capture
  // ----------------------------------------
  wire        cap_valid;
  wire [16:0] cap_word;
  wire [16:0] addr_word;
  wire [16:0] event_word;

  assign cap_valid  = debug_module_enable && (match_a || match_c);
  // comparator a wins when both fire
  assign addr_word  = match_a ? match_addr_a : match_addr_c;
  // event-only words carry only which comparator fired
  assign event_word = {15'h0000, match_c, match_a};
  assign cap_word   = event_only ? event_word : addr_word;

  dcr_fifo #(
    .WIDTH (17),
    .AW    (FIFO_AW)
  ) u_fifo (
    .pclk     (pclk),
    .presetn  (presetn),
    .flush    (clear_all),
    .wr_valid (cap_valid),
    .wr_data  (cap_word),
    .wr_ready (fifo_ready),
    .rd_pop   (pop),
    .rd_data  (trace_word),
    .rd_valid (trace_valid)
  );

endmodule

`default_nettype wire

//--- include/dcr_defines.vh
// register indices, field positions and reset values of the debug
// compare and trace block; byte address on apb is four times the index
`ifndef DCR_DEFINES_VH
`define DCR_DEFINES_VH

// ----------------------------------------
// register indices
// ----------------------------------------
`define DCR_IDX_CCL     6'h05
`define DCR_IDX_FH      6'h06
`define DCR_IDX_FL      6'h07
`define DCR_IDX_CAX     6'h08
`define DCR_IDX_CTRL    6'h10
`define DCR_IDX_FX      6'h11

// ----------------------------------------
// fields
// ----------------------------------------
`define DCR_CAX_RWEN    7
`define DCR_CAX_RWVAL   6
`define DCR_CAX_PAGED_ACCESS_QUALIFIER  5
`define DCR_CAX_B16     0
`define DCR_CTRL_EN     0
`define DCR_CTRL_BEGIN  1
`define DCR_CTRL_EVONLY 2
`define DCR_FX_B16      0

// ----------------------------------------
// reset values and widths
// ----------------------------------------
`define DCR_RST_BYTE    8'h00
`define DCR_RST_BIT     1'b0
`define DCR_ZERO_WORD   32'h0000_0000
`define DCR_RST_ADDR    17'h00000
`define DCR_PAGE_LSB_W  14

`endif

//--- core/dcr_cmp.v
// one address comparator with direction and paged-access qualifiers
// assumes core bus signals are synchronous to pclk
`timescale 1ns/10ps
`default_nettype none
`include "dcr_defines.vh"

module dcr_cmp (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // core bus
  input  wire        core_valid,
  input  wire        core_read,
  input  wire        core_paged,
  input  wire [2:0]  core_page,
  input  wire [16:0] core_addr,
  // settings
  input  wire [16:0] cmp_value,
  input  wire        direction_qualifier_enable,
  input  wire        direction_match_value,
  input  wire        paged_access_qualifier,
  // result
  output reg         match,
  output reg  [16:0] match_addr
);

  wire [16:0] eff_addr;
  wire        hit;

  // paged access: page value on top of the low offset bits
  assign eff_addr = core_paged ?
    {core_page, core_addr[`DCR_PAGE_LSB_W-1:0]} : core_addr;

  assign hit = core_valid &&
               (core_paged == paged_access_qualifier) &&
               (eff_addr == cmp_value) &&
               (!direction_qualifier_enable ||
                (core_read == direction_match_value));

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match      <= `DCR_RST_BIT;
      match_addr <= `DCR_RST_ADDR;
    end else begin
      match      <= hit;
      match_addr <= eff_addr;
    end
  end

endmodule

`default_nettype wire

//--- core/dcr_fifo.v
// trace word store with push, pop and flush
// assumes push and pop are single-cycle strobes on pclk
`timescale 1ns/10ps
`default_nettype none

module dcr_fifo #(
  parameter WIDTH = 17,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             pclk,
  input  wire             presetn,
  input  wire             flush,
  // fill side
  input  wire             wr_valid,
  input  wire [WIDTH-1:0] wr_data,
  output wire             wr_ready,
  // drain side
  input  wire             rd_pop,
  output wire [WIDTH-1:0] rd_data,
  output wire             rd_valid
);

  reg [WIDTH-1:0] mem [0:(1<<AW)-1];
  reg [AW:0]      wptr;
  reg [AW:0]      rptr;

  assign rd_valid = (wptr != rptr);
  assign wr_ready = (wptr != {~rptr[AW], rptr[AW-1:0]});
  assign rd_data  = mem[rptr[AW-1:0]];

  always @(posedge pclk) begin
    if (wr_valid && wr_ready && !flush) begin
      mem[wptr[AW-1:0]] <= wr_data;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr <= {(AW+1){1'b0}};
      rptr <= {(AW+1){1'b0}};
    end else if (flush) begin
      wptr <= {(AW+1){1'b0}};
      rptr <= {(AW+1){1'b0}};
    end else begin
      if (wr_valid && wr_ready) begin
        wptr <= wptr + 1'b1;
      end
      // advance on read of the low byte
      if (rd_pop && rd_valid) begin
        rptr <= rptr + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

//--- tb/dcr_core_model.sv
// core bus partner: one-cycle accesses on request of the bench
// assumes pclk is the bus clock of the block
`timescale 1ns/10ps
`default_nettype none
module dcr_core_model (
  // clock
  input  wire logic        pclk,
  // core bus
  output logic        core_valid,
  output logic        core_read,
  output logic        core_paged,
  output logic [2:0]  core_page,
  output logic [16:0] core_addr
);
  initial begin
    {core_valid, core_read, core_paged, core_page, core_addr} = 23'h0;
  end
  task access(input logic rd, input logic pg, input logic [2:0] pv, input logic [16:0] a);
    @(posedge pclk);
    core_valid <= 1'b1;
    core_read  <= rd;
    core_paged <= pg;
    core_page  <= pv;
    core_addr  <= a;
    @(posedge pclk);
    // released bus shows the inverse, not the last value
    core_valid <= 1'b0;
    core_read  <= ~rd;
    core_paged <= ~pg;
    core_page  <= ~pv;
    core_addr  <= ~a;
  endtask
endmodule
`default_nettype wire

//--- tb/dcr_top_asserts.sv
// port checker of dcr_top, bound after the module
// assumes one clock pclk and async active-low presetn
`timescale 1ns/10ps
`default_nettype none
module dcr_top_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        core_valid,
  input wire logic        core_paged,
  input wire logic [2:0]  core_page,
  input wire logic [16:0] core_addr,
  input wire logic [15:0] cmp_a_value,
  input wire logic [7:0]  cmp_c_high,
  input wire logic        match_a,
  input wire logic        match_c
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_c_match; match_c |-> $past(core_valid && !core_paged && !core_addr[16]
    && core_addr[15:8] == cmp_c_high); endproperty
  a_c_match: assert property (p_c_match) else $error("match c without cause");
  property p_a_flat; match_a && !$past(core_paged) |-> $past(core_addr[15:0] == cmp_a_value);
  endproperty
  a_a_flat: assert property (p_a_flat) else $error("match a on wrong flat address");
  property p_a_paged; match_a && $past(core_paged)
    |-> $past({core_page[1:0], core_addr[13:0]} == cmp_a_value); endproperty
  a_a_paged: assert property (p_a_paged) else $error("match a on wrong page");
  property p_a_cause; match_a |-> $past(core_valid); endproperty
  a_a_cause: assert property (p_a_cause) else $error("match a without access");
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("no answer after one wait");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_err; pslverr |-> pready && psel && penable; endproperty
  a_err: assert property (p_err) else $error("error outside an access");
  property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("unused read bits set");
endmodule
bind dcr_top dcr_top_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .core_valid(core_valid), .core_paged(core_paged), .core_page(core_page),
  .core_addr(core_addr), .cmp_a_value(cmp_a_value), .cmp_c_high(cmp_c_high),
  .match_a(match_a), .match_c(match_c));
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench of dcr_top: apb master, core bus model
// assumes byte address is four times the register index
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, core_reset_req;
  logic [7:0]  paddr, cmp_c_high;
  logic [31:0] pwdata, prdata;
  logic        core_valid, core_read, core_paged, match_a, match_c;
  logic [2:0]  core_page;
  logic [16:0] core_addr;
  logic [15:0] cmp_a_value;
  int          err_total, n_checks, cyc;
  dcr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_valid(core_valid), .core_read(core_read),
    .core_paged(core_paged), .core_page(core_page), .core_addr(core_addr),
    .cmp_a_value(cmp_a_value), .cmp_c_high(cmp_c_high), .core_reset_req(core_reset_req),
    .match_a(match_a), .match_c(match_c));
  dcr_core_model model (.pclk(pclk), .core_valid(core_valid), .core_read(core_read),
    .core_paged(core_paged), .core_page(core_page), .core_addr(core_addr));
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task rd(input string nm, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, x, q);
  endtask
  task acc(input logic r, input logic pg, input logic [2:0] pv, input logic [16:0] a,
           input logic [1:0] m);
    model.access(r, pg, pv, a);
    @(posedge pclk);
    chk("match", {30'h0, m}, {30'h0, match_c, match_a});
  endtask
  task pulse_reset;
    @(posedge pclk);
    core_reset_req <= 1'b1;
    @(posedge pclk);
    core_reset_req <= 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    logic [31:0] q;
    logic e;
    rd("ccl", 8'h14, 32'h0);
    rd("fh", 8'h18, 32'h0);
    rd("cax", 8'h20, 32'h0);
    apb(1'b0, 8'h04, 32'h0, q, e);
    chk("slverr", 32'h1, {31'h0, e});
  endtask
  task t_regs;
    wr(8'h14, 32'h0000_00a5);
    rd("ccl", 8'h14, 32'ha5);
    wr(8'h18, 32'h0000_00ff);
    rd("fh", 8'h18, 32'h0);
    wr(8'h20, 32'h0000_00ff);
    rd("cax", 8'h20, 32'he1);
    wr(8'h14, 32'h0000_0034);
  endtask
  task t_dir;
    wr(8'h20, 32'h40);
    acc(1'b0, 1'b0, 3'h0, 17'h01234, 2'b11);
    wr(8'h20, 32'hc0);
    acc(1'b0, 1'b0, 3'h0, 17'h01234, 2'b10);
    acc(1'b1, 1'b0, 3'h0, 17'h01234, 2'b11);
    wr(8'h20, 32'h80);
    acc(1'b0, 1'b0, 3'h0, 17'h01234, 2'b11);
  endtask
  task t_page;
    cmp_a_value <= 16'h5234;
    wr(8'h20, 32'h21);
    acc(1'b1, 1'b1, 3'h5, 17'h01234, 2'b01);
    acc(1'b1, 1'b0, 3'h0, 17'h15234, 2'b00);
    wr(8'h20, 32'h01);
    acc(1'b1, 1'b0, 3'h0, 17'h15234, 2'b01);
    acc(1'b1, 1'b1, 3'h5, 17'h01234, 2'b00);
    wr(8'h20, 32'h00);
    acc(1'b1, 1'b0, 3'h0, 17'h15234, 2'b00);
    cmp_a_value <= 16'h1234;
  endtask
  task t_trace;
    wr(8'h40, 32'h01);
    acc(1'b0, 1'b0, 3'h0, 17'h01234, 2'b11);
    acc(1'b0, 1'b0, 3'h0, 17'h00000, 2'b00);
    rd("fx", 8'h44, 32'h0);
    rd("fh", 8'h18, 32'h12);
    rd("fl", 8'h1c, 32'h34);
    rd("fl", 8'h1c, 32'h0);
  endtask
  task t_event;
    wr(8'h40, 32'h05);
    acc(1'b0, 1'b0, 3'h0, 17'h01234, 2'b11);
    rd("fh", 8'h18, 32'h0);
    rd("fl", 8'h1c, 32'h3);
    rd("fl", 8'h1c, 32'h0);
  endtask
  task t_keep;
    wr(8'h40, 32'h01);
    acc(1'b0, 1'b0, 3'h0, 17'h01234, 2'b11);
    pulse_reset();
    rd("ccl", 8'h14, 32'h34);
    rd("fh", 8'h18, 32'h12);
    rd("fl", 8'h1c, 32'h34);
    wr(8'h40, 32'h03);
    pulse_reset();
    rd("ccl", 8'h14, 32'h0);
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, core_reset_req, paddr} = 13'h0;
    {pwdata, cmp_a_value, cmp_c_high} = {32'h0, 16'h1234, 8'h12};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_dir();
    t_page();
    t_trace();
    t_event();
    t_keep();
    end_of_test();
  end
endmodule
`default_nettype wire
